// File: hw/ucm_modes.sv
// Mode and pin routing for the main UART control channel and two
// pass-through channels. Assumes a command decoder outside that turns
// main-channel frames into register requests, and a link that carries bits.
//
// Behaviour
// - One main control channel and two pass-through channels cross the link.
// - Base mode gives register access to local and remote devices.
// - Main channel starts in base mode after power-up.
// - Bypass ignores register commands but still forwards traffic over the link.
// - Pin bypass and timed soft-bypass may be entered and left any time without reset.
// - Pass-through channels forward data, never touch registers.
// - Main channel receives on pin fifteen, transmits on pin sixteen.
// - Control enable bit 5 disconnects pins, bit 4 blocks remote access.
// - Soft-bypass enable requests bypass; timeout picks 2, 8, 32 ms or none.
// - Soft-bypass takes effect only while UART activity is present.
// - No transition for the timeout returns the channel to base mode.
// - No-timeout setting holds bypass until power cycle.
// - Remote pin enable lets pin ten high force bypass, low release.
// - Local pin enable uses general pin two instead of pin ten.
// - Bypass control bit 3 enables parity, bits 6 and 2 hold timeout setting.
// - Pass-through one uses pins eleven and twelve; two shares fifteen and sixteen.
// - Pass-through enable bit 5 enables channel two, bit 4 channel one.
// - Interface select bit 4 low enables UART; loaded from strap at power-up.
// - Pass-through config bits 7/3 pick bit rate, bits 6/2 parity.
`timescale 1ns/10ps

module ucm_modes
    import ucm_pkg::*;
#(
    parameter int unsigned TO_SHORT_CYC = UCM_TO_SHORT_MS * UCM_CLK_KHZ,
    parameter int unsigned TO_MID_CYC   = UCM_TO_MID_MS * UCM_CLK_KHZ,
    parameter int unsigned TO_LONG_CYC  = UCM_TO_LONG_MS * UCM_CLK_KHZ
) (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     arst_n,
    // Straps and mode pins
    input  wire logic     config_strap_zero,
    input  wire logic     multifunction_pin_ten,
    input  wire logic     local_general_pin_two,
    // Shared main / pass-through two pins
    input  wire logic     multifunction_pin_fifteen,
    output logic          multifunction_pin_sixteen_out,
    output logic          multifunction_pin_sixteen_oe,
    // Pass-through one pins
    input  wire logic     multifunction_pin_eleven,
    output logic          multifunction_pin_twelve_out,
    output logic          multifunction_pin_twelve_oe,
    // Link side bit streams
    input  wire logic     link_main_in,
    output logic          link_main_out,
    input  wire logic     link_pt1_in,
    output logic          link_pt1_out,
    input  wire logic     link_pt2_in,
    output logic          link_pt2_out,
    // Register requests from the main channel decoder
    input  wire logic     cmd_valid,
    input  wire ucm_cmd_t cmd,
    output logic          rsp_valid,
    output logic [7:0]    rsp_rdata,
    output logic          remote_fwd,
    output ucm_cmd_t      remote_cmd,
    // Status and settings
    output logic          bypass_active,
    output logic          bypass_parity_en,
    output logic [7:0]    pt_config
);

    ucm_state_t st_reg;
    ucm_state_t st_next;

    logic                main_active;
    logic                pt1_on;
    logic                pt2_on;
    logic                hard_sel;
    logic                activity;
    logic [1:0]          to_code;
    logic [UCM_TO_W-1:0] to_limit;
    logic                to_hit;
    logic                take_cmd;
    logic [7:0]          rd_data;

    // Channel ownership; main channel wins the shared pins
    assign main_active = !st_reg.if_sel[UCM_IF_SEL_BIT]
                         && !st_reg.cc_en[UCM_CC_PIN_DIS_BIT];
    assign pt1_on      = st_reg.pt_en[UCM_PT1_EN_BIT];
    assign pt2_on      = st_reg.pt_en[UCM_PT2_EN_BIT] && !main_active;

    // Pin-driven bypass; local pin takes over from pin ten
    always_comb begin
        if (st_reg.byp_ctl[UCM_BYP_LOC_PIN_BIT]) begin
            hard_sel = local_general_pin_two;
        end else if (st_reg.byp_ctl[UCM_BYP_REM_PIN_BIT]) begin
            hard_sel = multifunction_pin_ten;
        end else begin
            hard_sel = 1'b0;
        end
    end

    // Any edge on either direction of the main channel counts as activity
    assign activity = |(st_reg.rx_prev ^ {multifunction_pin_fifteen, link_main_in});

    // Timeout select: bit 2 low half, bit 6 high half of the code
    assign to_code = {st_reg.byp_ctl[UCM_BYP_TO_HI_BIT],
                      st_reg.byp_ctl[UCM_BYP_TO_LO_BIT]};
    always_comb begin
        case (to_code)
            UCM_TO_2MS:  to_limit = UCM_TO_W'(TO_SHORT_CYC - 1);
            UCM_TO_8MS:  to_limit = UCM_TO_W'(TO_MID_CYC - 1);
            UCM_TO_32MS: to_limit = UCM_TO_W'(TO_LONG_CYC - 1);
            default:     to_limit = UCM_TO_W'(TO_LONG_CYC - 1);
        endcase
    end
    assign to_hit = (st_reg.to_cnt >= to_limit);

    // Register commands are dropped in bypass or with the channel off pins
    assign take_cmd = cmd_valid && main_active && !st_reg.bypass;

    // Local read mux; unmapped offsets read as zero
    always_comb begin
        case (cmd.addr)
            UCM_ADDR_CC_EN:   rd_data = st_reg.cc_en;
            UCM_ADDR_PT_EN:   rd_data = st_reg.pt_en;
            UCM_ADDR_IF_SEL:  rd_data = st_reg.if_sel;
            UCM_ADDR_BYP_CTL: rd_data = st_reg.byp_ctl;
            UCM_ADDR_PT_CFG:  rd_data = st_reg.pt_cfg;
            default:          rd_data = UCM_RD_ZERO;
        endcase
    end

    // Next-state logic for registers, soft-bypass and pin routing
    always_comb begin
        st_next            = st_reg;
        st_next.rsp_valid  = 1'b0;
        st_next.remote_fwd = 1'b0;
        st_next.rx_prev    = {multifunction_pin_fifteen, link_main_in};

        // Strap capture on the first edge after reset release
        if (!st_reg.strap_done) begin
            st_next.strap_done                 = 1'b1;
            st_next.if_sel[UCM_IF_SEL_BIT]     = config_strap_zero;
        end

        // Soft-bypass sequencing
        case (st_reg.mode)
            UCM_BASE: begin
                st_next.to_cnt = '0;
                if (st_reg.strap_done && st_reg.byp_ctl[UCM_BYP_SOFT_EN_BIT]) begin
                    st_next.mode = UCM_ARMED;
                end
            end
            UCM_ARMED: begin
                st_next.to_cnt = '0;
                if (!st_reg.byp_ctl[UCM_BYP_SOFT_EN_BIT]) begin
                    st_next.mode = UCM_BASE;
                end else if (activity) begin
                    st_next.mode = (to_code == UCM_TO_NONE) ? UCM_HELD
                                                            : UCM_SOFT;
                end
            end
            UCM_SOFT: begin
                if (!st_reg.byp_ctl[UCM_BYP_SOFT_EN_BIT]) begin
                    st_next.mode = UCM_BASE;
                end else if (activity) begin
                    st_next.to_cnt = '0;
                end else if (to_hit) begin
                    // Drop the request so the channel does not re-arm by itself
                    st_next.mode                            = UCM_BASE;
                    st_next.byp_ctl[UCM_BYP_SOFT_EN_BIT]    = 1'b0;
                end else begin
                    st_next.to_cnt = st_reg.to_cnt + 1'b1;
                end
            end
            UCM_HELD: begin
                st_next.mode = UCM_HELD;
            end
            default: begin
                st_next.mode = UCM_BASE;
            end
        endcase

        // Register access; a software write after the hardware clear wins
        if (take_cmd) begin
            if (cmd.remote) begin
                if (!st_reg.cc_en[UCM_CC_REM_DIS_BIT]) begin
                    st_next.remote_fwd = 1'b1;
                    st_next.remote_cmd = cmd;
                end
            end else begin
                st_next.rsp_valid = 1'b1;
                st_next.rsp_rdata = cmd.write ? UCM_RD_ZERO : rd_data;
                if (cmd.write) begin
                    case (cmd.addr)
                        UCM_ADDR_CC_EN:   st_next.cc_en   = cmd.wdata;
                        UCM_ADDR_PT_EN:   st_next.pt_en   = cmd.wdata;
                        UCM_ADDR_IF_SEL:  st_next.if_sel  = cmd.wdata;
                        UCM_ADDR_BYP_CTL: st_next.byp_ctl = cmd.wdata;
                        UCM_ADDR_PT_CFG:  st_next.pt_cfg  = cmd.wdata;
                        default:          st_next.cc_en   = st_next.cc_en;
                    endcase
                end
            end
        end

        // Bypass is the union of pin and soft requests
        st_next.bypass = hard_sel
                         || (st_next.mode == UCM_SOFT)
                         || (st_next.mode == UCM_HELD);

        // Main channel traffic crosses the link in every mode
        st_next.link_main_out = main_active ? multifunction_pin_fifteen
                                            : UCM_IDLE;
        st_next.link_pt1_out  = pt1_on ? multifunction_pin_eleven
                                       : UCM_IDLE;
        st_next.link_pt2_out  = pt2_on ? multifunction_pin_fifteen
                                       : UCM_IDLE;

        // Pin sixteen: main channel first, else channel two, else released
        if (main_active) begin
            st_next.pin16_out = link_main_in;
            st_next.pin16_oe  = 1'b1;
        end else if (pt2_on) begin
            st_next.pin16_out = link_pt2_in;
            st_next.pin16_oe  = 1'b1;
        end else begin
            st_next.pin16_out = UCM_IDLE;
            st_next.pin16_oe  = 1'b0;
        end
        st_next.pin12_out = pt1_on ? link_pt1_in : UCM_IDLE;
        st_next.pin12_oe  = pt1_on;
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg               <= '0;
            st_reg.cc_en         <= UCM_RST_CC_EN;
            st_reg.pt_en         <= UCM_RST_PT_EN;
            st_reg.if_sel        <= UCM_RST_IF_SEL;
            st_reg.byp_ctl       <= UCM_RST_BYP_CTL;
            st_reg.pt_cfg        <= UCM_RST_PT_CFG;
            st_reg.mode          <= UCM_BASE;
            st_reg.rx_prev       <= {UCM_IDLE, UCM_IDLE};
            st_reg.pin16_out     <= UCM_IDLE;
            st_reg.pin12_out     <= UCM_IDLE;
            st_reg.link_main_out <= UCM_IDLE;
            st_reg.link_pt1_out  <= UCM_IDLE;
            st_reg.link_pt2_out  <= UCM_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign multifunction_pin_sixteen_out = st_reg.pin16_out;
    assign multifunction_pin_sixteen_oe  = st_reg.pin16_oe;
    assign multifunction_pin_twelve_out  = st_reg.pin12_out;
    assign multifunction_pin_twelve_oe   = st_reg.pin12_oe;
    assign link_main_out                 = st_reg.link_main_out;
    assign link_pt1_out                  = st_reg.link_pt1_out;
    assign link_pt2_out                  = st_reg.link_pt2_out;
    assign rsp_valid                     = st_reg.rsp_valid;
    assign rsp_rdata                     = st_reg.rsp_rdata;
    assign remote_fwd                    = st_reg.remote_fwd;
    assign remote_cmd                    = st_reg.remote_cmd;
    assign bypass_active                 = st_reg.bypass;
    assign bypass_parity_en              = st_reg.byp_ctl[UCM_BYP_PARITY_BIT];
    assign pt_config                     = st_reg.pt_cfg;

    // Checks
    a_base_at_start: assert property (@(posedge clk) disable iff (!arst_n)
        !st_reg.strap_done |-> st_reg.mode == UCM_BASE)
        else $error("mode left base before strap capture");

    a_strap_load: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(st_reg.strap_done) |-> st_reg.if_sel[UCM_IF_SEL_BIT]
            == $past(config_strap_zero))
        else $error("interface select not loaded from strap");

    a_bypass_ignore: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && st_reg.bypass) |=> !st_reg.rsp_valid && !st_reg.remote_fwd)
        else $error("register command answered in bypass");

    a_base_access: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && !cmd.remote && main_active && !st_reg.bypass)
            |=> st_reg.rsp_valid)
        else $error("local command not answered in base mode");

    a_remote_block: assert property (@(posedge clk) disable iff (!arst_n)
        (cmd_valid && cmd.remote && st_reg.cc_en[UCM_CC_REM_DIS_BIT])
            |=> !st_reg.remote_fwd)
        else $error("remote access forwarded while blocked");

    a_pin_release: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg.cc_en[UCM_CC_PIN_DIS_BIT] && !st_reg.pt_en[UCM_PT2_EN_BIT])
            |=> !st_reg.pin16_oe)
        else $error("pin sixteen driven while main channel disconnected");

    a_pt1_route: assert property (@(posedge clk) disable iff (!arst_n)
        pt1_on |=> st_reg.pin12_oe && st_reg.pin12_out == $past(link_pt1_in))
        else $error("pass-through one not routed to pin twelve");

    a_hard_bypass: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg.byp_ctl[UCM_BYP_REM_PIN_BIT] && !st_reg.byp_ctl[UCM_BYP_LOC_PIN_BIT]
            && multifunction_pin_ten) |=> st_reg.bypass)
        else $error("pin ten high did not force bypass");

    a_soft_act: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg.mode == UCM_ARMED && !activity) |=> st_reg.mode == UCM_ARMED
            || st_reg.mode == UCM_BASE)
        else $error("soft bypass entered without activity");

    a_soft_timeout: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg.mode == UCM_SOFT && !activity && to_hit
            && st_reg.byp_ctl[UCM_BYP_SOFT_EN_BIT]) |=> st_reg.mode == UCM_BASE)
        else $error("soft bypass did not time out");

    a_held_stays: assert property (@(posedge clk) disable iff (!arst_n)
        st_reg.mode == UCM_HELD |=> st_reg.mode == UCM_HELD && st_reg.bypass)
        else $error("held bypass released");

endmodule // ucm_modes

// File: hw/ucm_pkg.sv
// Package for the UART control channel mode and routing block.
// Assumes a 100 MHz core clock and synchronous pin inputs.
package ucm_pkg;

    // Register offsets
    localparam logic [15:0] UCM_ADDR_CC_EN   = 16'h0001;
    localparam logic [15:0] UCM_ADDR_PT_EN   = 16'h0003;
    localparam logic [15:0] UCM_ADDR_IF_SEL  = 16'h0006;
    localparam logic [15:0] UCM_ADDR_BYP_CTL = 16'h0048;
    localparam logic [15:0] UCM_ADDR_PT_CFG  = 16'h004F;

    // Reset values
    localparam logic [7:0] UCM_RST_CC_EN   = 8'h08;
    localparam logic [7:0] UCM_RST_PT_EN   = 8'h00;
    localparam logic [7:0] UCM_RST_IF_SEL  = 8'h80;
    localparam logic [7:0] UCM_RST_BYP_CTL = 8'h42;
    localparam logic [7:0] UCM_RST_PT_CFG  = 8'h00;
    localparam logic [7:0] UCM_RD_ZERO     = 8'h00;

    // Field positions
    localparam int unsigned UCM_CC_PIN_DIS_BIT   = 5;
    localparam int unsigned UCM_CC_REM_DIS_BIT   = 4;
    localparam int unsigned UCM_PT2_EN_BIT       = 5;
    localparam int unsigned UCM_PT1_EN_BIT       = 4;
    localparam int unsigned UCM_IF_SEL_BIT       = 4;
    localparam int unsigned UCM_BYP_REM_PIN_BIT  = 5;
    localparam int unsigned UCM_BYP_LOC_PIN_BIT  = 4;
    localparam int unsigned UCM_BYP_PARITY_BIT   = 3;
    localparam int unsigned UCM_BYP_TO_LO_BIT    = 2;
    localparam int unsigned UCM_BYP_SOFT_EN_BIT  = 1;
    localparam int unsigned UCM_BYP_TO_HI_BIT    = 6;
    localparam int unsigned UCM_PT2_RATE_BIT     = 7;
    localparam int unsigned UCM_PT2_PARITY_BIT   = 6;
    localparam int unsigned UCM_PT1_RATE_BIT     = 3;
    localparam int unsigned UCM_PT1_PARITY_BIT   = 2;

    // Soft-bypass timeout codes {hi, lo}
    localparam logic [1:0] UCM_TO_2MS  = 2'h0;
    localparam logic [1:0] UCM_TO_8MS  = 2'h1;
    localparam logic [1:0] UCM_TO_32MS = 2'h2;
    localparam logic [1:0] UCM_TO_NONE = 2'h3;

    // Timing
    localparam int unsigned UCM_CLK_KHZ     = 100_000;
    localparam int unsigned UCM_TO_SHORT_MS = 2;
    localparam int unsigned UCM_TO_MID_MS   = 8;
    localparam int unsigned UCM_TO_LONG_MS  = 32;
    localparam int unsigned UCM_CFG_GAP_US  = 10;
    localparam int unsigned UCM_TO_W        = 22;

    // UART line idles high
    localparam logic UCM_IDLE = 1'b1;

    typedef enum logic [1:0] {
        UCM_BASE,
        UCM_ARMED,
        UCM_SOFT,
        UCM_HELD
    } ucm_mode_t;

    // Register access request from the main channel command decoder
    typedef struct packed {
        logic        write;
        logic        remote;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ucm_cmd_t;

    typedef struct packed {
        logic [7:0]          cc_en;
        logic [7:0]          pt_en;
        logic [7:0]          if_sel;
        logic [7:0]          byp_ctl;
        logic [7:0]          pt_cfg;
        logic                strap_done;
        ucm_mode_t           mode;
        logic [UCM_TO_W-1:0] to_cnt;
        logic [1:0]          rx_prev;
        logic                bypass;
        logic                pin16_out;
        logic                pin16_oe;
        logic                pin12_out;
        logic                pin12_oe;
        logic                link_main_out;
        logic                link_pt1_out;
        logic                link_pt2_out;
        logic                rsp_valid;
        logic [7:0]          rsp_rdata;
        logic                remote_fwd;
        ucm_cmd_t            remote_cmd;
    } ucm_state_t;

endpackage

// File: verification/ucm_far_host.sv
// Far-end host model: drives the three link bit streams into the block.
// Assumes the bench clock; lines idle high whenever the model is released.
`timescale 1ns/10ps
module ucm_far_host (
    // Clock and control
    input  wire logic        clk,
    input  wire logic        en,
    input  wire logic [31:0] seed,
    // Link streams toward the device
    output logic             main_o,
    output logic             pt1_o,
    output logic             pt2_o
);
    logic [31:0] st_reg = 32'h0000_0001;
    // New bits after each falling edge; released lines go to idle level
    always @(negedge clk) begin
        if (en) begin
            st_reg <= {st_reg[30:0], st_reg[31] ^ st_reg[21] ^ st_reg[1] ^ st_reg[0]};
            {main_o, pt1_o, pt2_o} <= st_reg[2:0];
        end else begin
            st_reg <= seed | 32'h0000_0001;
            {main_o, pt1_o, pt2_o} <= 3'h7;
        end
    end
endmodule // ucm_far_host

// File: verification/tb.sv
// Bench for the UART mode block: registers, routing, bypass modes.
// Assumes the package and the far-end model are compiled first.
`timescale 1ns/10ps
module tb;
    import ucm_pkg::*;
    localparam int L0 = 20, L1 = 40, L2 = 80;
    localparam logic [15:0] RA [5] = '{16'h0001, 16'h0003, 16'h0006, 16'h0048, 16'h004F};
    localparam logic [7:0]  RV [5] = '{8'h08, 8'h00, 8'h80, 8'h42, 8'h00};
    logic        clk = 0, arst_n = 0, strap = 0, pin10 = 0, gpin2 = 0, pin15 = 1, pin11 = 1;
    logic        p16o, p16e, p12o, p12e, lmi, lmo, l1i, l1o, l2i, l2o, rsp_valid, remote_fwd;
    logic        byp, par, cmd_valid = 0, en_far = 0, mon = 0, pt1_on = 0, own2 = 0;
    logic [7:0]  rsp_rdata, ptc, cfg;
    ucm_cmd_t    cmd = '0, remote_cmd;
    logic [31:0] rnd = 32'h4116_a40d, tmp, seed = 32'h0000_0001;
    int          fail_count = 0, comparisons = 0, cyc = 0, lim [3] = '{L0, L1, L2};

    ucm_modes #(.TO_SHORT_CYC(L0), .TO_MID_CYC(L1), .TO_LONG_CYC(L2)) dut_u (
        .clk(clk), .arst_n(arst_n), .config_strap_zero(strap), .multifunction_pin_ten(pin10),
        .local_general_pin_two(gpin2), .multifunction_pin_fifteen(pin15),
        .multifunction_pin_sixteen_out(p16o), .multifunction_pin_sixteen_oe(p16e),
        .multifunction_pin_eleven(pin11), .multifunction_pin_twelve_out(p12o),
        .multifunction_pin_twelve_oe(p12e), .link_main_in(lmi), .link_main_out(lmo),
        .link_pt1_in(l1i), .link_pt1_out(l1o), .link_pt2_in(l2i), .link_pt2_out(l2o),
        .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .remote_fwd(remote_fwd), .remote_cmd(remote_cmd), .bypass_active(byp),
        .bypass_parity_en(par), .pt_config(ptc));
    ucm_far_host far_u (.clk(clk), .en(en_far), .seed(seed), .main_o(lmi), .pt1_o(l1i),
        .pt2_o(l2i));

    always #5 clk = ~clk;

    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // One request, answer looked at in the cycle it stands
    task automatic rq(input logic w, r, input logic [15:0] a, input logic [7:0] d,
                      input logic ack, input logic [7:0] e);
        @(negedge clk);
        cmd_valid <= 1'b1;
        cmd <= {w, r, a, d};
        @(negedge clk);
        if (r) chk("remote_fwd", ack, remote_fwd);
        else chk("rsp_valid", ack, rsp_valid);
        if (ack && r) chk("remote_cmd", {w, r, a, d}, remote_cmd);
        if (ack && !r) chk("rsp_rdata", e, rsp_rdata);
        cmd_valid <= 1'b0;
        if (w) repeat (1000) @(negedge clk); // Quiet gap after a write
    endtask

    task automatic pulse();
        pin15 <= 1'b0;
        @(negedge clk);
        pin15 <= 1'b1;
        @(negedge clk);
    endtask

    task results();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Random pin traffic; monitor reads values before this edge's updates
    always @(negedge clk) begin
        if (mon) begin
            tmp = xs();
            pin15 <= tmp[0];
            pin11 <= tmp[1];
            chk("link_out", pin15, own2 ? l2o : lmo);
            chk("pin16_out", own2 ? l2i : lmi, p16o);
            chk("pin16_oe", 1, p16e);
            chk("pin12_oe", pt1_on, p12e);
            chk("pin12_out", pt1_on ? l1i : 1'b1, p12o);
            chk("link_pt1_out", pt1_on ? pin11 : 1'b1, l1o);
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 5; i++) rq(0, 0, RA[i], 0, 1, RV[i]);
        rq(0, 0, 16'h0022, 0, 1, 8'h00);
        rq(1, 0, UCM_ADDR_BYP_CTL, 8'h08, 1, 0);
        chk("bypass_parity_en", 1, par);
        seed = xs();
        en_far <= 1;
        mon <= 1;
        rq(0, 1, 16'h0010, 0, 1, 0);
        rq(1, 0, UCM_ADDR_CC_EN, 8'h18, 1, 0);
        rq(0, 1, 16'h0010, 0, 0, 0);
        cfg = 8'(xs());
        rq(1, 0, UCM_ADDR_PT_CFG, cfg, 1, 0);
        chk("pt_config", cfg, ptc);
        mon <= 0;
        rq(1, 0, UCM_ADDR_PT_EN, 8'h10, 1, 0);
        pt1_on <= 1;
        mon <= 1;
        // Hard bypass from remote pin, then local pin with priority
        rq(1, 0, UCM_ADDR_BYP_CTL, 8'h20, 1, 0);
        pin10 <= 1;
        repeat (3) @(negedge clk);
        chk("bypass_active", 1, byp);
        rq(0, 0, UCM_ADDR_PT_EN, 0, 0, 0);
        pin10 <= 0;
        repeat (3) @(negedge clk);
        chk("bypass_active", 0, byp);
        rq(1, 0, UCM_ADDR_BYP_CTL, 8'h30, 1, 0);
        pin10 <= 1;
        repeat (3) @(negedge clk);
        chk("bypass_active", 0, byp);
        gpin2 <= 1;
        repeat (3) @(negedge clk);
        chk("bypass_active", 1, byp);
        gpin2 <= 0;
        pin10 <= 0;
        mon <= 0;
        en_far <= 0;
        @(negedge clk);
        pin15 <= 1;
        // Soft bypass over the three timed codes
        for (int k = 0; k < 3; k++) begin
            rq(1, 0, UCM_ADDR_BYP_CTL, {1'b0, k[1], 3'h0, k[0], 2'h2}, 1, 0);
            chk("bypass_active", 0, byp);
            pulse();
            repeat (3) @(negedge clk);
            chk("bypass_active", 1, byp);
            rq(0, 0, UCM_ADDR_CC_EN, 0, 0, 0);
            repeat (lim[k] - 6) @(negedge clk);
            chk("bypass_active", 1, byp);
            repeat (1) @(negedge clk);
            chk("bypass_active", 0, byp);
            rq(0, 0, UCM_ADDR_BYP_CTL, 0, 1, {1'b0, k[1], 3'h0, k[0], 2'h0});
        end
        rq(1, 0, UCM_ADDR_BYP_CTL, 8'h46, 1, 0);
        pulse();
        repeat (200) @(negedge clk);
        chk("bypass_active", 1, byp);
        // Strap high disables the channel, then strap low restores it
        for (int s = 1; s >= 0; s--) begin
            strap <= s[0];
            arst_n = 0;
            pt1_on <= 0;
            repeat (3) @(negedge clk);
            arst_n = 1;
            repeat (2) @(negedge clk);
            chk("bypass_active", 0, byp);
            rq(0, 0, UCM_ADDR_IF_SEL, 0, !s[0], 8'h80);
        end
        // Pass-through two takes the shared pins
        rq(1, 0, UCM_ADDR_BYP_CTL, 8'h00, 1, 0);
        rq(1, 0, UCM_ADDR_PT_EN, 8'h20, 1, 0);
        rq(1, 0, UCM_ADDR_CC_EN, 8'h20, 1, 0);
        own2 <= 1;
        en_far <= 1;
        mon <= 1;
        repeat (200) @(negedge clk);
        rq(0, 0, UCM_ADDR_PT_EN, 0, 0, 0);
        results();
    end
endmodule // tb
